// >>> logic/rhg_fifo.sv
`default_nettype none

module rhg_fifo
   import rhg_pkg::*;
#(
   parameter int WIDTH = 17,
   parameter int DEPTH = 32
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   input wire logic flush,
   // Fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wptr;
      logic [AW:0] rptr;
   } rhg_fifo_st_t;

   rhg_fifo_st_t s_r;
   rhg_fifo_st_t s_nxt;
   logic [WIDTH-1:0] mem [DEPTH];
   logic do_push;
   logic do_pop;

   // ****************************************
   // Flags
   // ****************************************
   // Extra pointer bit tells full from empty without a counter
   assign in_ready = (s_r.wptr[AW] == s_r.rptr[AW]) || (s_r.wptr[AW-1:0] != s_r.rptr[AW-1:0]);
   assign out_valid = (s_r.wptr != s_r.rptr);
   assign out_data = mem[s_r.rptr[AW-1:0]];
   assign do_push = in_valid && in_ready && !flush;
   assign do_pop = out_valid && out_ready && !flush;

   always_comb
   begin
      s_nxt = s_r;
      if (flush)
      begin
         s_nxt = '0;
      end
      else
      begin
         if (do_push)
         begin
            s_nxt.wptr = s_r.wptr + 1'b1;
         end
         if (do_pop)
         begin
            s_nxt.rptr = s_r.rptr + 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // Storage has no reset: contents are only read behind a valid pointer
   always_ff @(posedge clock)
   begin
      if (do_push)
      begin
         mem[s_r.wptr[AW-1:0]] <= in_data;
      end
   end

endmodule

`default_nettype wire

// >>> logic/rhg_gate.sv
`default_nettype none

module rhg_gate
   import rhg_pkg::*;
#(
   parameter int REP_LIMIT = RHG_REP_LIMIT,
   parameter int WIN_BITS = RHG_WIN_BITS,
   parameter int WIN_TOL = RHG_WIN_TOL,
   parameter int FIFO_DEPTH = RHG_FIFO_DEPTH
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Control
   input wire logic start,
   input wire logic word16,
   // Entropy source
   input wire rhg_raw_t raw,
   // Consumer
   output rhg_word_t out_word,
   output logic out_valid,
   input wire logic out_ready,
   // Status
   output logic fail_flag,
   output rhg_cause_t fail_cause,
   output logic running
);

   localparam int RW = $clog2(REP_LIMIT + 1);
   localparam int WW = $clog2(WIN_BITS);
   localparam int OW = $clog2(WIN_BITS + 1);
   localparam logic [RW-1:0] REP_LAST = RW'(REP_LIMIT - 1);
   localparam logic [RW-1:0] REP_FULL = RW'(REP_LIMIT);
   localparam logic [WW-1:0] WIN_LAST = WW'(WIN_BITS - 1);
   localparam logic [OW-1:0] ONES_LO = OW'(WIN_BITS / 2 - WIN_TOL);
   localparam logic [OW-1:0] ONES_HI = OW'(WIN_BITS / 2 + WIN_TOL);

   typedef struct packed {
      rhg_state_t state;
      logic mode16;
      logic fail;
      rhg_cause_t cause;
      logic run_bit;
      logic [RW-1:0] run_len;
      logic [WW-1:0] win_cnt;
      logic [OW-1:0] ones;
      logic [REP_LIMIT-1:0] dly;
      logic [RW-1:0] dly_cnt;
      logic [RHG_WORD_W-1:0] asm_bits;
      logic [4:0] asm_cnt;
      logic [RHG_WORD_W-1:0] prev;
      logic prev_ok;
      rhg_word_t pend;
      logic pend_valid;
      rhg_word_t out_word;
      logic out_valid;
      logic live;
   } rhg_gate_st_t;

   rhg_gate_st_t s_r;
   rhg_gate_st_t s_nxt;
   logic [OW-1:0] ones_sum;
   logic [RHG_WORD_W-1:0] word;
   logic [4:0] word_last;
   logic dead;
   logic stat;
   logic rep;
   logic push;
   logic pop;
   logic flush;
   logic fifo_in_ready;
   logic fifo_out_valid;
   rhg_word_t fifo_out;

   // ****************************************
   // Word buffer
   // ****************************************
   rhg_fifo #(
      .WIDTH($bits(rhg_word_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .reset_n(reset_n),
      .flush(flush),
      .in_valid(push),
      .in_data(s_r.pend),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_out_valid),
      .out_data(fifo_out),
      .out_ready(pop)
   );

   // ****************************************
   // Health tests, assembly and gating
   // ****************************************
   always_comb
   begin
      s_nxt = s_r;
      dead = 1'b0;
      stat = 1'b0;
      rep = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      flush = 1'b0;
      ones_sum = s_r.ones + OW'(raw.value);
      word_last = s_r.mode16 ? 5'h0f : 5'h07;
      if (s_r.mode16)
      begin
         word = {s_r.asm_bits[RHG_WORD_W-2:0], s_r.dly[REP_LIMIT-1]};
      end
      else
      begin
         word = {8'h00, s_r.asm_bits[RHG_BYTE_W-2:0], s_r.dly[REP_LIMIT-1]};
      end
      if (start)
      begin
         // Restart or reset is the only way out of a failure
         s_nxt = '0;
         s_nxt.state = RHG_ST_POWERUP;
         s_nxt.mode16 = word16;
         flush = 1'b1;
      end
      else if (s_r.state == RHG_ST_POWERUP || s_r.state == RHG_ST_RUN)
      begin
         if (s_r.pend_valid && fifo_in_ready)
         begin
            // A full buffer stalls assembly, never the health tests
            push = 1'b1;
            s_nxt.pend_valid = 1'b0;
         end
         if (raw.valid)
         begin
            if (s_r.run_len != '0 && raw.value == s_r.run_bit)
            begin
               s_nxt.run_len = s_r.run_len + 1'b1;
               if (s_r.run_len == REP_LAST)
               begin
                  dead = 1'b1;
               end
            end
            else
            begin
               s_nxt.run_bit = raw.value;
               s_nxt.run_len = RW'(1);
            end
            // Every raw bit counts; no on-demand trigger
            if (s_r.win_cnt == WIN_LAST)
            begin
               // Bias bound keeps per-bit entropy high
               if (ones_sum < ONES_LO || ones_sum > ONES_HI)
               begin
                  stat = 1'b1;
               end
               else if (s_r.state == RHG_ST_POWERUP)
               begin
                  s_nxt.state = RHG_ST_RUN;
               end
               s_nxt.win_cnt = '0;
               s_nxt.ones = '0;
            end
            else
            begin
               s_nxt.win_cnt = s_r.win_cnt + 1'b1;
               s_nxt.ones = ones_sum;
            end
            // A bit is used only after the dead-source check has seen
            // as many newer bits as it needs to fire
            s_nxt.dly = {s_r.dly[REP_LIMIT-2:0], raw.value};
            if (s_r.dly_cnt != REP_FULL)
            begin
               s_nxt.dly_cnt = s_r.dly_cnt + 1'b1;
            end
            // A word leaving for the buffer this cycle frees the holding slot
            else if (!s_r.pend_valid || fifo_in_ready)
            begin
               s_nxt.asm_bits = word;
               if (s_r.asm_cnt == word_last)
               begin
                  s_nxt.asm_cnt = '0;
                  if (s_r.prev_ok && word == s_r.prev)
                  begin
                     rep = 1'b1;
                  end
                  s_nxt.prev = word;
                  s_nxt.prev_ok = 1'b1;
                  s_nxt.pend.data = word;
                  s_nxt.pend.wide = s_r.mode16;
                  s_nxt.pend_valid = 1'b1;
               end
               else
               begin
                  s_nxt.asm_cnt = s_r.asm_cnt + 1'b1;
               end
            end
         end
         // Consumer takes a word only while valid is shown
         if (s_r.out_valid && out_ready)
         begin
            s_nxt.out_valid = 1'b0;
         end
         if (s_r.state == RHG_ST_RUN && fifo_out_valid && (!s_r.out_valid || out_ready))
         begin
            pop = 1'b1;
            s_nxt.out_word = fifo_out;
            s_nxt.out_valid = 1'b1;
         end
         if (dead || stat || rep)
         begin
            // Drop everything in flight, including the word on the port
            s_nxt.state = RHG_ST_FAIL;
            s_nxt.fail = 1'b1;
            s_nxt.out_valid = 1'b0;
            s_nxt.pend_valid = 1'b0;
            s_nxt.asm_cnt = '0;
            push = 1'b0;
            pop = 1'b0;
            flush = 1'b1;
            if (dead)
            begin
               s_nxt.cause = RHG_CAUSE_DEAD;
            end
            else if (stat)
            begin
               s_nxt.cause = RHG_CAUSE_STAT;
            end
            else
            begin
               s_nxt.cause = RHG_CAUSE_REPEAT;
            end
         end
      end
      // Registered decode keeps the status pin free of glitches
      s_nxt.live = (s_nxt.state == RHG_ST_RUN);
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign out_word = s_r.out_word;
   assign out_valid = s_r.out_valid;
   assign fail_flag = s_r.fail;
   assign fail_cause = s_r.cause;
   assign running = s_r.live;

endmodule

`default_nettype wire

// >>> logic/rhg_pkg.sv
// Behaviour
// - Dead-source check runs from generator start
// - No word delivered after dead source
// - Suppress words using bits after failure
// - Online statistical test at start and running
// - Output held until power-up test passes
// - Online test runs continuously on raw bits
// - Words delivered as 8 or 16 bits
// - Internal bits carry entropy above 0.97; the window bound admits 416 to 608 ones in 1024 bits
// - Successive words compared, repeats rejected
`default_nettype none

package rhg_pkg;

   // ****************************************
   // Sizes and test limits
   // ****************************************
   localparam int RHG_WORD_W = 16;
   localparam int RHG_BYTE_W = 8;
   localparam int RHG_FIFO_DEPTH = 32;
   localparam int RHG_REP_LIMIT = 32;
   localparam int RHG_WIN_BITS = 1024;
   localparam int RHG_WIN_TOL = 96;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      RHG_ST_IDLE = 2'b00,
      RHG_ST_POWERUP = 2'b01,
      RHG_ST_RUN = 2'b10,
      RHG_ST_FAIL = 2'b11
   } rhg_state_t;

   typedef enum logic [1:0] {
      RHG_CAUSE_NONE = 2'b00,
      RHG_CAUSE_DEAD = 2'b01,
      RHG_CAUSE_STAT = 2'b10,
      RHG_CAUSE_REPEAT = 2'b11
   } rhg_cause_t;

   typedef struct packed {
      logic valid;
      logic value;
   } rhg_raw_t;

   typedef struct packed {
      logic [RHG_WORD_W-1:0] data;
      logic wide;
   } rhg_word_t;

endpackage

`default_nettype wire

// >>> tb/rhg_consumer.sv
`default_nettype none

module rhg_consumer
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Control
   input wire logic fail_flag,
   input wire logic slow,
   output logic out_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   // Slow mode stalls at random; a set failure flag stops all reads
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         out_ready <= 1'b0;
      else
         out_ready <= !fail_flag && (!slow || $urandom_range(1) == 1);
   end
endmodule

`default_nettype wire

// >>> tb/rhg_gate_properties.sv
`default_nettype none

module rhg_gate_properties
   import rhg_pkg::*;
#(
   parameter int REP_LIMIT = 32,
   parameter int WIN_BITS = 1024
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Inputs
   input wire logic start,
   input wire rhg_raw_t raw,
   input wire logic out_ready,
   // Outputs
   input wire rhg_word_t out_word,
   input wire logic out_valid,
   input wire logic fail_flag,
   input wire rhg_cause_t fail_cause,
   input wire logic running
);
   timeunit 1ns;
   timeprecision 1ns;
   // ***
   // Equal-bit run and bits since start
   // ***
   int run_r, nbits_r;
   logic last_r, arm_r;

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         run_r <= 0;
         nbits_r <= 0;
         last_r <= 1'b0;
         arm_r <= 1'b0;
      end
      else if (start)
      begin
         run_r <= 0;
         nbits_r <= 0;
         arm_r <= 1'b1;
      end
      else if (raw.valid)
      begin
         run_r <= (run_r > 0 && raw.value == last_r) ? run_r + 1 : 1;
         // Saturates, only the first window matters
         nbits_r <= (nbits_r > WIN_BITS) ? nbits_r : nbits_r + 1;
         last_r <= raw.value;
      end
   end

   // ***
   // Properties
   // ***
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);

   sequence s_stuck;
      arm_r && !fail_flag && !start && raw.valid
         && raw.value == last_r && run_r == REP_LIMIT - 1;
   endsequence
   sequence s_wait;
      out_valid && !out_ready && !start;
   endsequence

   property p_dead;
      s_stuck |=> fail_flag;
   endproperty
   property p_hold;
      s_wait |=> fail_flag || (out_valid && $stable(out_word));
   endproperty
   property p_gated;
      out_valid |-> running && !fail_flag;
   endproperty
   property p_sticky;
      fail_flag && !start |=> fail_flag;
   endproperty
   property p_cause_hold;
      fail_flag && !start |=> $stable(fail_cause);
   endproperty
   property p_restart;
      start |=> !fail_flag && !running && !out_valid;
   endproperty
   property p_cause;
      fail_flag == (fail_cause != RHG_CAUSE_NONE);
   endproperty
   property p_powerup;
      $rose(running) |-> nbits_r == WIN_BITS;
   endproperty

   a_dead: assert property (p_dead) else $error("dead source missed");
   a_hold: assert property (p_hold) else $error("word not held");
   a_gated: assert property (p_gated) else $error("word offered");
   a_sticky: assert property (p_sticky) else $error("flag lost");
   a_cause_hold: assert property (p_cause_hold) else $error("cause moved");
   a_restart: assert property (p_restart) else $error("start ignored");
   a_cause: assert property (p_cause) else $error("cause wrong");
   a_powerup: assert property (p_powerup) else $error("early run");
endmodule

bind rhg_gate rhg_gate_properties #(.REP_LIMIT(REP_LIMIT), .WIN_BITS(WIN_BITS)) u_props (
   .clock(clock), .reset_n(reset_n), .start(start), .raw(raw), .out_ready(out_ready),
   .out_word(out_word), .out_valid(out_valid), .fail_flag(fail_flag),
   .fail_cause(fail_cause), .running(running)
);

`default_nettype wire

// >>> tb/rhg_gate_test.sv
`default_nettype none

module rhg_gate_test
   import rhg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int REP = RHG_REP_LIMIT;
   localparam int WB = 64;
   localparam int WT = 12;

   logic clock, reset_n, start, word16, slow, out_ready, out_valid, fail_flag, running;
   rhg_raw_t raw;
   rhg_word_t out_word;
   rhg_cause_t fail_cause, exp_cause;
   int n_fail, checks_done, run, nb, ones, cnt;
   logic lastb, m16, have_prev, exp_fail, exp_run;
   logic [15:0] acc, prev;
   logic dl[$];
   rhg_word_t expq[$];

   rhg_gate #(.WIN_BITS(WB), .WIN_TOL(WT)) dut (
      .clock(clock), .reset_n(reset_n), .start(start), .word16(word16), .raw(raw),
      .out_word(out_word), .out_valid(out_valid), .out_ready(out_ready),
      .fail_flag(fail_flag), .fail_cause(fail_cause), .running(running)
   );
   rhg_consumer u_cons (
      .clock(clock), .reset_n(reset_n), .fail_flag(fail_flag), .slow(slow),
      .out_ready(out_ready)
   );

   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   task automatic check(input logic [16:0] seen, input logic [16:0] exp, input string what);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: %s %h not %h", $time, what, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Reference model: one raw bit per call, taken at the next edge
   task automatic feed(input logic b);
      logic [2:0] f;
      logic [15:0] w;
      f = 3'b000;
      raw <= '{valid: 1'b1, value: b};
      if (!exp_fail)
      begin
         run = (nb > 0 && b == lastb) ? run + 1 : 1;
         lastb = b;
         nb++;
         ones += b;
         f[2] = (run == REP);
         if (nb % WB == 0)
         begin
            f[1] = (ones < WB / 2 - WT || ones > WB / 2 + WT);
            ones = 0;
         end
         dl.push_back(b);
         if (dl.size() > REP)
         begin
            acc = {acc[14:0], dl.pop_front()};
            cnt++;
            if (cnt == (m16 ? 16 : 8))
            begin
               w = m16 ? acc : {8'h00, acc[7:0]};
               f[0] = have_prev && w == prev;
               if (f == 3'b000)
                  expq.push_back('{data: w, wide: m16});
               prev = w;
               have_prev = 1'b1;
               cnt = 0;
            end
         end
         // Dead source outranks statistics, which outrank repeats
         if (f[2])
            exp_cause = RHG_CAUSE_DEAD;
         else if (f[1])
            exp_cause = RHG_CAUSE_STAT;
         else if (f[0])
            exp_cause = RHG_CAUSE_REPEAT;
         exp_fail = exp_fail || f != 3'b000;
         exp_run = exp_run || (nb == WB && !exp_fail);
      end
      @(posedge clock);
      #1;
   endtask

   // Kind 0 random, 1 random then stuck, 2 biased repeating pattern
   task automatic run_test(input logic w16, input int n, input int kind, input logic slw);
      logic b;
      slow <= slw;
      word16 <= w16;
      start <= 1'b1;
      raw <= '0;
      run = 0;
      nb = 0;
      ones = 0;
      cnt = 0;
      m16 = w16;
      have_prev = 1'b0;
      exp_fail = 1'b0;
      exp_run = 1'b0;
      exp_cause = RHG_CAUSE_NONE;
      dl.delete();
      expq.delete();
      @(posedge clock);
      #1;
      start <= 1'b0;
      for (int i = 0; i < n; i++)
      begin
         if (kind == 2)
            b = (i % 4 != 3);
         else if (kind == 1 && i >= 64)
            b = 1'b1;
         else
            b = 1'($urandom_range(1));
         feed(b);
      end
      raw <= '0;
      for (int i = 0; i < 300 && expq.size() > 0 && !exp_fail; i++)
         @(posedge clock);
      repeat (2) @(posedge clock);
      #1;
      check(17'(fail_flag), 17'(exp_fail), "flag");
      check(17'(fail_cause), 17'(exp_cause), "cause");
      check(17'(running), 17'(exp_run && !exp_fail), "running");
      if (!exp_fail)
         check(17'(expq.size()), 17'h0, "words left");
      $display("test done: kind %0d, %0d bits", kind, n);
   endtask

   // Handshake looked at mid-cycle, where both sides have settled
   always @(negedge clock)
   begin
      if (reset_n === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1)
      begin
         if (expq.size() == 0)
            check(17'h1, 17'h0, "stray word");
         else
            check(out_word, expq.pop_front(), "word");
      end
   end

   // Under 3000 cycles are needed even when every test drains slowly
   initial
   begin
      repeat (5000) @(posedge clock);
      n_fail++;
      close_out();
   end

   initial
   begin
      reset_n = 1'b0;
      start = 1'b0;
      word16 = 1'b0;
      slow = 1'b0;
      raw = '0;
      n_fail = 0;
      checks_done = 0;
      void'($urandom(32'hda4974a8));
      repeat (3) @(posedge clock);
      #1;
      reset_n <= 1'b1;
      run_test(1'b1, 400, 0, 1'b1);
      run_test(1'b0, 200, 0, 1'b0);
      run_test(1'b1, 160, 1, 1'b1);
      run_test(1'b1, 64, 2, 1'b0);
      run_test(1'b0, 64, 2, 1'b1);
      reset_n <= 1'b0;
      @(posedge clock);
      #1;
      check(17'({out_valid, fail_flag, running}), 17'h0, "reset");
      reset_n <= 1'b1;
      run_test(1'b1, 120, 0, 1'b0);
      close_out();
   end
endmodule

`default_nettype wire
